/* sdc_cb_monitor.sv */
// Checker on the configuration bank ports.
// Assumes one clock domain; bound by the statement at the foot.
`timescale 1ns/1ns
`default_nettype none
module sdc_cb_monitor (
	input wire logic        sys_clk,
	input wire logic        reset,
	input wire logic [15:0] fb_addr,
	input wire logic        fb_wr,
	input wire logic        fb_rd,
	input wire logic [15:0] fb_rdata,
	input wire logic        eeprom_load,
	input wire logic        end_of_frame,
	input wire logic        start_of_frame,
	input wire logic        first_sync_event,
	input wire logic        second_sync_event,
	input wire logic        latch_in,
	input wire logic        watchdog_trigger_signal,
	input wire logic        watchdog_expired,
	input wire logic [7:0]  pin_dir,
	input wire logic [7:0]  dio_out,
	input wire logic [7:0]  dio_oe,
	input wire logic [7:0]  in_data,
	input wire logic [3:0]  port_link_enhanced,
	input wire logic        dc_latch_unit_enable,
	input wire logic        dc_sync_unit_enable,
	input wire logic        device_emulation,
	input wire logic        al_event_request0
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	// A load in the read cycle would make the answer older than the enables
	wire cfg_rd = fb_rd && fb_addr == 16'h0141 && !eeprom_load;
	wire info_rd = fb_rd && fb_addr == 16'h014e;
	wire ctl_wr = fb_wr && fb_addr == 16'h0120;
	wire out_ev = end_of_frame | first_sync_event | second_sync_event | watchdog_trigger_signal;
	link_map_a: assert property (cfg_rd |=>
		port_link_enhanced == (fb_rdata[7:4] | {4{fb_rdata[1]}})) else $error("link enables wrong");
	units_en_a: assert property (cfg_rd |=>
		{dc_latch_unit_enable, dc_sync_unit_enable, device_emulation} == {fb_rdata[3:2], fb_rdata[0]})
		else $error("unit enables wrong");
	info_rsv_a: assert property (info_rd |=> fb_rdata[15:4] == 12'h000)
		else $error("reserved info bits set");
	info_loaded_a: assert property (eeprom_load ##1 info_rd |=> fb_rdata[1])
		else $error("loaded flag missing");
	event_set_a: assert property (ctl_wr && !device_emulation |=> al_event_request0)
		else $error("event request not set");
	oe_mode_a: assert property (dio_oe != pin_dir |-> dio_oe == 8'hff)
		else $error("pin enables wrong");
	out_cause_a: assert property ($changed(dio_out) |-> $past(out_ev | watchdog_expired))
		else $error("outputs moved without event");
	in_cause_a: assert property ($changed(in_data) |->
		$past(start_of_frame | latch_in | first_sync_event | second_sync_event))
		else $error("inputs sampled without event");
	// Main scenarios reached
	cover property (info_rd);
	cover property (ctl_wr ##1 al_event_request0);
	cover property (watchdog_expired ##1 dio_out == 8'h00);
endmodule // sdc_cb_monitor
bind sdc_config_bank sdc_cb_monitor sdc_cb_monitor_i (.*);
`default_nettype wire

/* sdc_config_bank.v */
// Configuration, information and digital I/O configuration registers
// of the slave controller, with application-layer control/status
// handling and the digital I/O timing block.
// Assumes EEPROM data arrives with a one-cycle load pulse and that
// both register ports are synchronous to sys_clk.
// Also assumes pin events arrive as single-cycle pulses from the
// frame and clock logic around it.
`timescale 1ns/1ns
`default_nettype none
`include "sdc_defs.vh"

// Register map, identical from both ports:
//   0x120 application-layer control, written by the fieldbus
//   0x130 application-layer status, host-written unless emulating
//   0x141 controller configuration, read-only
//   0x14e local interface information, read-only
//   0x150 digital I/O configuration, read-only
//   0x220 event request in bit 0, read-only
// Writes to read-only or unmapped offsets are dropped.
// Unmapped reads return zero.
// Information word: bit 3 interface configuration invalid, bit 2
// interface active, bit 1 image loaded, bit 0 acknowledge by write.
// Event request 0 is raised by a fieldbus control write outside emulation and cleared
// by the host's acknowledge, a write or a read as strapped.

// Overview of operation
// R1: Per-port link bits default on, EEPROM later
// R2: Every-port bit overrides per-port bits
// R3: Bit 3 enables clock latch unit
// R4: Bit 2 enables clock sync unit
// R5: Emulation off: host writes status register
// R6: Emulation on: status mirrors control writes
// R7: Link bits load only at first EEPROM
// R8: Info reports config invalid and interface active
// R9: Info bit 1 shows EEPROM loaded
// R10: Info bit 0 shows acknowledge by write
// R11: Host write or read clears event bit
// R12: Output update field picks output event
// R13: Output-valid mode updates at watchdog trigger
// R14: Input sample field picks input event
// R15: Watchdog bit picks immediate or deferred reset
// R16: Direction mode bit forces all bidirectional
// R17: Strobe source and polarity from config
// R18: Every I/O config bit loads from EEPROM
// R19: Config registers read-only from both sides
// R20: Reserved info bits read zero
module sdc_config_bank (
	input  wire        sys_clk,
	input  wire        reset,
	// Fieldbus-side register port
	input  wire [15:0] fb_addr,
	input  wire        fb_wr,
	input  wire        fb_rd,
	input  wire [15:0] fb_wdata,
	output reg  [15:0] fb_rdata,
	// Local host interface register port
	input  wire [15:0] lh_addr,
	input  wire        lh_wr,
	input  wire        lh_rd,
	input  wire [15:0] lh_wdata,
	output reg  [15:0] lh_rdata,
	// Configuration EEPROM load
	input  wire        eeprom_load,
	input  wire [7:0]  eeprom_ctrl_cfg,
	input  wire [7:0]  eeprom_dio_cfg,
	input  wire        ack_by_write_cfg,
	// Local interface health
	input  wire        local_if_config_invalid,
	input  wire        local_if_active,
	// Process data events and pins
	input  wire        end_of_frame,
	input  wire        start_of_frame,
	input  wire        first_sync_event,
	input  wire        second_sync_event,
	input  wire        latch_in,
	input  wire        watchdog_trigger_signal,
	input  wire        watchdog_expired,
	input  wire [7:0]  out_data,
	input  wire [7:0]  pin_dir,
	input  wire [7:0]  dio_in,
	output wire [7:0]  dio_out,
	output wire [7:0]  dio_oe,
	output wire [7:0]  in_data,
	output wire        output_valid_strobe,
	// Unit enables, emulation mode and event request
	output wire [3:0]  port_link_enhanced,
	output wire        dc_latch_unit_enable,
	output wire        dc_sync_unit_enable,
	output wire        device_emulation,
	output wire        al_event_request0
);

	// Register storage
	reg  [7:0]  ctrl_cfg;
	reg  [7:0]  dio_cfg;
	reg         cfg_loaded;
	reg         ack_by_write_enabled;
	reg         strap_taken;
	reg         invalid_q;
	reg         active_q;
	reg  [15:0] al_control;
	reg  [15:0] al_status;
	reg         event_req0;
	// Next-state and read-mux values
	reg  [7:0]  next_ctrl_cfg;
	reg  [15:0] next_fb_rdata;
	reg  [15:0] next_lh_rdata;
	wire [15:0] info;

	// Named views of the link detection fields
	wire [3:0]  cfg_port_bits  = ctrl_cfg[`SDC_CFG_PORT_HI:`SDC_CFG_PORT_LO];
	wire        cfg_every_port = ctrl_cfg[`SDC_CFG_LINK_ALL];

	// Address decodes; both ports see the same offsets
	wire fb_ctl_wr = fb_wr && (fb_addr == `SDC_OFF_AL_CONTROL);
	wire lh_ctl_wr = lh_wr && (lh_addr == `SDC_OFF_AL_CONTROL);
	wire lh_ctl_rd = lh_rd && (lh_addr == `SDC_OFF_AL_CONTROL);
	wire lh_sta_wr = lh_wr && (lh_addr == `SDC_OFF_AL_STATUS);

	// Host acknowledge clears the event request
	// Which host access counts is fixed by the strap at start-up
	wire ack_clear = ack_by_write_enabled ? lh_ctl_wr : lh_ctl_rd; // R11

	// Emulation selects who owns the status register
	// and stops control writes from raising event requests
	assign device_emulation = ctrl_cfg[`SDC_CFG_EMUL];

	// Latch and sync units gated off to save power
	// The units live elsewhere; only their enables leave this block
	assign dc_latch_unit_enable = ctrl_cfg[`SDC_CFG_LATCH_EN]; // R3
	assign dc_sync_unit_enable  = ctrl_cfg[`SDC_CFG_SYNC_EN]; // R4
	assign al_event_request0    = event_req0;

	// Information word; upper bits are reserved
	// Health flags and the strap are registered, so this is glitch free
	assign info = {12'h000, invalid_q, active_q, cfg_loaded, // R8 R9 R20
		ack_by_write_enabled}; // R10

	// EEPROM image merge: link bits kept once the first load is done.
	// A later reload may still retune the clock units and emulation,
	// but never the link detection a running network depends on.
	always @* begin
		next_ctrl_cfg = eeprom_ctrl_cfg;
		if (cfg_loaded) begin
			next_ctrl_cfg = (ctrl_cfg & `SDC_CFG_FIRST_MASK) | // R7
				(eeprom_ctrl_cfg & ~`SDC_CFG_FIRST_MASK);
		end
	end

	// Configuration registers change only through EEPROM loads; bus
	// writes to them are simply not decoded
	// Reset keeps every port's link detection on until an image arrives
	// The loaded flag never drops again until the next reset
	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			ctrl_cfg   <= `SDC_CFG_RESET; // R1
			dio_cfg    <= `SDC_DIO_RESET;
			cfg_loaded <= 1'b0;
		end else if (eeprom_load) begin
			ctrl_cfg   <= next_ctrl_cfg; // R1 R7 R19
			dio_cfg    <= eeprom_dio_cfg; // R18 R19
			cfg_loaded <= 1'b1; // R9
		end
	end

	// Acknowledge mode is a strap caught after reset release, never
	// under the asynchronous reset itself
	// Limitation: a changed strap only takes effect after a new reset
	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			ack_by_write_enabled <= 1'b0;
			strap_taken          <= 1'b0;
		end else if (!strap_taken) begin
			ack_by_write_enabled <= ack_by_write_cfg; // R10
			strap_taken          <= 1'b1;
		end
	end

	// Health flags registered so readers see a stable value
	// Both are levels from the interface logic, not events
	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			invalid_q <= 1'b0;
			active_q  <= 1'b0;
		end else begin
			invalid_q <= local_if_config_invalid; // R8
			active_q  <= local_if_active; // R8
		end
	end

	// Application-layer control written by the fieldbus; the status
	// either mirrors it under emulation or belongs to the host.
	// Reserved status bits are masked so they always read as zero.
	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			al_control <= 16'h0000;
			al_status  <= 16'h0001;
		end else begin
			if (fb_ctl_wr) begin
				al_control <= fb_wdata;
			end
			if (device_emulation) begin
				if (fb_ctl_wr) begin
					al_status <= fb_wdata & `SDC_AL_STATUS_MASK; // R6
				end
			end else if (lh_sta_wr) begin
				al_status <= lh_wdata & `SDC_AL_STATUS_MASK; // R5
			end
		end
	end

	// Event request bit: a new fieldbus write wins over a clear in the
	// same cycle so no request is ever lost.
	// Under emulation the control write is mirrored, not announced.
	// The host's clear only lands when no new request arrives with it.
	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			event_req0 <= 1'b0;
		end else if (fb_ctl_wr && !device_emulation) begin
			event_req0 <= 1'b1;
		end else if (ack_clear) begin
			event_req0 <= 1'b0; // R11
		end
	end

	// Fieldbus read mux; unmapped offsets return zero
	// so probing software never picks up stale bus values
	always @* begin
		case (fb_addr)
		`SDC_OFF_AL_CONTROL: next_fb_rdata = al_control;
		`SDC_OFF_AL_STATUS:  next_fb_rdata = al_status;
		`SDC_OFF_CTRL_CFG:   next_fb_rdata = {8'h00, ctrl_cfg};
		`SDC_OFF_INFO:       next_fb_rdata = info;
		`SDC_OFF_DIO_CFG:    next_fb_rdata = {8'h00, dio_cfg};
		`SDC_OFF_EVENT_REQ:  next_fb_rdata = {15'h0000, event_req0};
		default:             next_fb_rdata = 16'h0000;
		endcase
	end

	// Local host read mux, the same map as the fieldbus side
	// so both masters always agree on what they see
	always @* begin
		case (lh_addr)
		`SDC_OFF_AL_CONTROL: next_lh_rdata = al_control;
		`SDC_OFF_AL_STATUS:  next_lh_rdata = al_status;
		`SDC_OFF_CTRL_CFG:   next_lh_rdata = {8'h00, ctrl_cfg};
		`SDC_OFF_INFO:       next_lh_rdata = info;
		`SDC_OFF_DIO_CFG:    next_lh_rdata = {8'h00, dio_cfg};
		`SDC_OFF_EVENT_REQ:  next_lh_rdata = {15'h0000, event_req0};
		default:             next_lh_rdata = 16'h0000;
		endcase
	end

	// Fieldbus read data held until the next fieldbus read strobe
	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			fb_rdata <= 16'h0000;
		end else if (fb_rd) begin
			fb_rdata <= next_fb_rdata;
		end
	end

	// Host read data held separately so one port never disturbs the
	// value the other is still collecting; both may read every cycle
	// and in any order
	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			lh_rdata <= 16'h0000;
		end else if (lh_rd) begin
			lh_rdata <= next_lh_rdata;
		end
	end

	// Link detection enables per port; kept apart so the override
	// stays in one place for every port
	sdc_link_enable u_link (
		.enhanced_link_every_port (cfg_every_port), // R2
		.enhanced_link_port       (cfg_port_bits),
		.port_link_enhanced       (port_link_enhanced)
	);

	// Digital I/O timing driven by the I/O configuration register
	// A reload takes effect at once for pin enables and strobe polarity, and for event choices from the next event onwards
	// The I/O block owns all pin timing; this one only hands it the register
	sdc_dio_ctrl u_dio (
		.sys_clk                 (sys_clk),
		.reset                   (reset),
		.dio_cfg                 (dio_cfg),
		.end_of_frame            (end_of_frame),
		.start_of_frame          (start_of_frame),
		.first_sync_event        (first_sync_event),
		.second_sync_event       (second_sync_event),
		.latch_in                (latch_in),
		.watchdog_trigger_signal (watchdog_trigger_signal),
		.watchdog_expired        (watchdog_expired),
		.out_data                (out_data),
		.pin_dir                 (pin_dir),
		.dio_in                  (dio_in),
		.dio_out                 (dio_out),
		.dio_oe                  (dio_oe),
		.in_data                 (in_data),
		.output_valid_strobe     (output_valid_strobe)
	);

endmodule // sdc_config_bank
`default_nettype wire

/* sdc_defs.vh */
// Offsets, field positions, reset values and event codes of the
// slave configuration and digital I/O control block.
// Assumes byte offsets as seen by both register ports.
`ifndef SDC_DEFS_VH
`define SDC_DEFS_VH

// Register offsets
`define SDC_OFF_AL_CONTROL   16'h0120
`define SDC_OFF_AL_STATUS    16'h0130
`define SDC_OFF_CTRL_CFG     16'h0141
`define SDC_OFF_INFO         16'h014e
`define SDC_OFF_DIO_CFG      16'h0150
`define SDC_OFF_EVENT_REQ    16'h0220

// Controller configuration fields
`define SDC_CFG_EMUL         0
`define SDC_CFG_LINK_ALL     1
`define SDC_CFG_SYNC_EN      2
`define SDC_CFG_LATCH_EN     3
`define SDC_CFG_PORT_LO      4
`define SDC_CFG_PORT_HI      7
`define SDC_CFG_RESET        8'hf2
// Bits 7:4 and 1 load only on the first EEPROM load
`define SDC_CFG_FIRST_MASK   8'hf2

// Digital I/O configuration fields
`define SDC_DIO_POLARITY     0
`define SDC_DIO_OV_MODE      1
`define SDC_DIO_BIDIR        2
`define SDC_DIO_WD_DEFER     3
`define SDC_DIO_IN_LO        4
`define SDC_DIO_IN_HI        5
`define SDC_DIO_OUT_LO       6
`define SDC_DIO_OUT_HI       7
`define SDC_DIO_RESET        8'h00

// Event selection codes
`define SDC_EV_FRAME         2'b00
`define SDC_EV_LATCH         2'b01
`define SDC_EV_FIRST_SYNC_EVENT         2'b10
`define SDC_EV_SECOND_SYNC_EVENT         2'b11

// Application-layer status writable bits
`define SDC_AL_STATUS_MASK   16'h003f

`endif

/* sdc_dio_ctrl.v */
// Digital I/O process-data timing: output update, input sampling,
// watchdog output reset, pin direction and output-valid strobe.
// Assumes event inputs are one-cycle pulses synchronous to sys_clk.
`timescale 1ns/1ns
`default_nettype none
`include "sdc_defs.vh"
module sdc_dio_ctrl (
	input  wire       sys_clk,
	input  wire       reset,
	input  wire [7:0] dio_cfg,
	input  wire       end_of_frame,
	input  wire       start_of_frame,
	input  wire       first_sync_event,
	input  wire       second_sync_event,
	input  wire       latch_in,
	input  wire       watchdog_trigger_signal,
	input  wire       watchdog_expired,
	input  wire [7:0] out_data,
	input  wire [7:0] pin_dir,
	input  wire [7:0] dio_in,
	output reg  [7:0] dio_out,
	output wire [7:0] dio_oe,
	output reg  [7:0] in_data,
	output reg        output_valid_strobe
);

	reg        latch_prev;
	reg        wd_pending;
	reg        out_event;
	reg        in_event;
	wire [1:0] out_sel = dio_cfg[`SDC_DIO_OUT_HI:`SDC_DIO_OUT_LO];
	wire [1:0] in_sel  = dio_cfg[`SDC_DIO_IN_HI:`SDC_DIO_IN_LO];
	wire       ov_mode = dio_cfg[`SDC_DIO_OV_MODE];
	wire       upd     = ov_mode ? watchdog_trigger_signal : out_event; // R13
	wire       latch_rise = latch_in & ~latch_prev;

	// Output event choice; code 01 gives no event at all
	always @* begin
		case (out_sel) // R12
		`SDC_EV_FRAME: out_event = end_of_frame;
		`SDC_EV_FIRST_SYNC_EVENT: out_event = first_sync_event;
		`SDC_EV_SECOND_SYNC_EVENT: out_event = second_sync_event;
		default:       out_event = 1'b0;
		endcase
	end

	// Input sample choice
	always @* begin
		case (in_sel) // R14
		`SDC_EV_FRAME: in_event = start_of_frame;
		`SDC_EV_LATCH: in_event = latch_rise;
		`SDC_EV_FIRST_SYNC_EVENT: in_event = first_sync_event;
		`SDC_EV_SECOND_SYNC_EVENT: in_event = second_sync_event;
		default:       in_event = 1'b0;
		endcase
	end

	// Output register with watchdog reset; a deferred reset replaces
	// the next update so stale data never reaches the pins
	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			dio_out    <= 8'h00;
			wd_pending <= 1'b0;
			in_data    <= 8'h00;
			latch_prev <= 1'b0;
			output_valid_strobe <= 1'b0;
		end else begin
			latch_prev <= latch_in;
			if (watchdog_expired && !dio_cfg[`SDC_DIO_WD_DEFER]) begin
				dio_out    <= 8'h00; // R15
				wd_pending <= 1'b0;
			end else if (upd && (wd_pending || watchdog_expired)) begin
				dio_out    <= 8'h00; // R15
				wd_pending <= 1'b0;
			end else if (upd) begin
				dio_out <= out_data;
			end else if (watchdog_expired) begin
				wd_pending <= 1'b1; // R15
			end
			if (in_event)
				in_data <= dio_in;
			// Strobe source and polarity
			output_valid_strobe <= upd ^ dio_cfg[`SDC_DIO_POLARITY]; // R17
		end
	end

	// Bidirectional mode drives every pin and ignores per-pin settings
	assign dio_oe = dio_cfg[`SDC_DIO_BIDIR] ? 8'hff : pin_dir; // R16

endmodule // sdc_dio_ctrl
`default_nettype wire

/* sdc_eeprom_model.sv */
// Configuration EEPROM source feeding the bank's load port.
// Assumes loads are requested just after a rising clock edge.
`timescale 1ns/1ns
`default_nettype none
module sdc_eeprom_model (
	input  wire logic       sys_clk,
	output var  logic       eeprom_load,
	output var  logic [7:0] eeprom_ctrl_cfg,
	output var  logic [7:0] eeprom_dio_cfg
);
	// Idle words are not a valid image
	initial begin
		eeprom_load = 1'h0;
		eeprom_ctrl_cfg = 8'h5a;
		eeprom_dio_cfg = 8'ha5;
	end
	// Whole image in one pulse; afterwards the inverse, so stale data never passes
	task load(input logic [7:0] c, input logic [7:0] d);
		eeprom_load <= 1'h1;
		eeprom_ctrl_cfg <= c;
		eeprom_dio_cfg <= d;
		@(posedge sys_clk);
		eeprom_load <= 1'h0;
		eeprom_ctrl_cfg <= ~c;
		eeprom_dio_cfg <= ~d;
	endtask
endmodule // sdc_eeprom_model
`default_nettype wire

/* sdc_link_enable.v */
// Per-port enhanced link detection enables.
// Assumes configuration bits come from registers in the parent.
`timescale 1ns/1ns
`default_nettype none
module sdc_link_enable (
	input  wire       enhanced_link_every_port,
	input  wire [3:0] enhanced_link_port,
	output wire [3:0] port_link_enhanced
);

	// Every-port bit overrides each per-port bit
	genvar i;
	generate
		for (i = 0; i < 4; i = i + 1) begin : g_port
			assign port_link_enhanced[i] = enhanced_link_every_port |
				enhanced_link_port[i]; // R1 R2
		end
	endgenerate

endmodule // sdc_link_enable
`default_nettype wire

/* slave_config_and_dio_control_tb.sv */
// Self-checking bench for the configuration bank.
// Assumes the checker binds itself and the EEPROM model drives loads.
`timescale 1ns/1ns
`default_nettype none
module slave_config_and_dio_control_tb;
	typedef struct packed {logic [7:0] c; logic [6:0] ev; logic [1:0] ou; logic iu; logic s;} sdc_row_t;
	logic        sys_clk = 1'h0, reset = 1'h1;
	logic        fb_wr = 1'h0, fb_rd = 1'h0, lh_wr = 1'h0, lh_rd = 1'h0;
	logic [15:0] fb_addr = 16'h0000, fb_wdata = 16'h0000, lh_addr = 16'h0000, lh_wdata = 16'h0000;
	logic [15:0] fb_rdata, lh_rdata, rdv;
	logic        ack_by_write_cfg = 1'h1, local_if_config_invalid = 1'h1, local_if_active = 1'h0;
	logic        eeprom_load, output_valid_strobe;
	logic [7:0]  eeprom_ctrl_cfg, eeprom_dio_cfg, dio_out, dio_oe, in_data;
	logic [7:0]  out_data = 8'h3c, dio_in = 8'hc3, pin_dir = 8'h5a, e_out = 8'h00, e_in = 8'h00;
	logic [6:0]  ev = 7'h00;
	logic [3:0]  port_link_enhanced;
	logic        dc_latch_unit_enable, dc_sync_unit_enable, device_emulation, al_event_request0;
	int          err_total = 0, checked = 0, cyc = 0;
	wire  [7:0]  units = {al_event_request0, device_emulation, dc_latch_unit_enable,
		dc_sync_unit_enable, port_link_enhanced};
	// Reset reads: port, offset, value
	logic [32:0] regs [7] = '{{1'h0, 16'h0141, 16'h00f2}, {1'h1, 16'h0141, 16'h00f2},
		{1'h0, 16'h014e, 16'h0009}, {1'h1, 16'h0150, 16'h0000}, {1'h1, 16'h0130, 16'h0001},
		{1'h0, 16'h0120, 16'h0000}, {1'h0, 16'h0220, 16'h0000}};
	// Event bits: latch, expiry, trigger, second_sync_event, first_sync_event, start, end
	sdc_row_t rows [16] = '{'{8'h00, 7'h01, 2'h1, 1'h0, 1'h1}, '{8'h00, 7'h02, 2'h0, 1'h1, 1'h0},
		'{8'h80, 7'h04, 2'h1, 1'h0, 1'h1}, '{8'hc0, 7'h08, 2'h1, 1'h0, 1'h1},
		'{8'h40, 7'h0f, 2'h0, 1'h1, 1'h0}, '{8'h10, 7'h40, 2'h0, 1'h1, 1'h0},
		'{8'h20, 7'h04, 2'h0, 1'h1, 1'h0}, '{8'h30, 7'h08, 2'h0, 1'h1, 1'h0},
		'{8'hc2, 7'h08, 2'h0, 1'h0, 1'h0}, '{8'hc2, 7'h10, 2'h1, 1'h0, 1'h1},
		'{8'h01, 7'h01, 2'h1, 1'h0, 1'h1}, '{8'h04, 7'h01, 2'h1, 1'h0, 1'h1},
		'{8'h00, 7'h20, 2'h2, 1'h0, 1'h0}, '{8'h08, 7'h01, 2'h1, 1'h0, 1'h1},
		'{8'h08, 7'h20, 2'h0, 1'h0, 1'h0}, '{8'h08, 7'h01, 2'h2, 1'h0, 1'h1}};
	sdc_eeprom_model sdc_eeprom_model_i (.sys_clk, .eeprom_load, .eeprom_ctrl_cfg, .eeprom_dio_cfg);
	sdc_config_bank sdc_config_bank_i (.sys_clk, .reset, .fb_addr, .fb_wr, .fb_rd, .fb_wdata,
		.fb_rdata, .lh_addr, .lh_wr, .lh_rd, .lh_wdata, .lh_rdata, .eeprom_load, .eeprom_ctrl_cfg,
		.eeprom_dio_cfg, .ack_by_write_cfg, .local_if_config_invalid, .local_if_active,
		.end_of_frame(ev[0]), .start_of_frame(ev[1]), .first_sync_event(ev[2]),
		.second_sync_event(ev[3]), .watchdog_trigger_signal(ev[4]), .watchdog_expired(ev[5]),
		.latch_in(ev[6]), .out_data, .pin_dir, .dio_in, .dio_out, .dio_oe, .in_data,
		.output_valid_strobe, .port_link_enhanced, .dc_latch_unit_enable, .dc_sync_unit_enable,
		.device_emulation, .al_event_request0);
	// 100 MHz clock
	always #5 sys_clk = ~sys_clk;
	// Cut a hang short; the run needs under a hundred cycles
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			err_total++;
			$display("[ERR] cycle limit expected 3000 seen %0d", cyc);
			tally_and_finish();
		end
	end
	task chk(input string n, input logic [15:0] e, input logic [15:0] g);
		checked++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	// Read answers a cycle late, so sample after a further edge
	task rd(input logic h, input logic [15:0] a);
		{lh_rd, fb_rd} <= h ? 2'h2 : 2'h1;
		lh_addr <= a;
		fb_addr <= a;
		@(posedge sys_clk);
		{lh_rd, fb_rd} <= 2'h0;
		@(posedge sys_clk);
		#1 rdv = h ? lh_rdata : fb_rdata;
	endtask
	task wr(input logic h, input logic [15:0] a, input logic [15:0] d);
		{lh_wr, fb_wr} <= h ? 2'h2 : 2'h1;
		lh_addr <= a;
		fb_addr <= a;
		lh_wdata <= d;
		fb_wdata <= d;
		@(posedge sys_clk);
		{lh_wr, fb_wr} <= 2'h0;
		#1;
	endtask
	task do_reset();
		reset <= 1'h1;
		repeat (6) @(posedge sys_clk);
		reset <= 1'h0;
		repeat (2) @(posedge sys_clk);
	endtask
	// New data and events land together; outputs show one edge later
	task dio_row(input sdc_row_t r);
		sdc_eeprom_model_i.load(8'h10, r.c);
		out_data <= ~out_data;
		dio_in <= ~dio_in;
		ev <= r.ev;
		@(posedge sys_clk);
		ev <= 7'h00;
		#1;
		if (r.ou != 2'h0) e_out = r.ou == 2'h1 ? out_data : 8'h00;
		if (r.iu) e_in = dio_in;
		chk("dio_out", e_out, dio_out);
		chk("in_data", e_in, in_data);
		chk("strobe", r.s ^ r.c[0], output_valid_strobe);
		chk("dio_oe", r.c[2] ? 8'hff : pin_dir, dio_oe);
	endtask
	task tally_and_finish();
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// Main sequence: reset values, loads, protection, events, then a second reset
	initial begin
		do_reset();
		foreach (regs[i]) begin
			rd(regs[i][32], regs[i][31:16]);
			chk("reset read", regs[i][15:0], rdv);
		end
		chk("units", 16'h000f, units);
		sdc_eeprom_model_i.load(8'h1c, 8'h00);
		rd(1'h0, 16'h014e);
		chk("info", 16'h000b, rdv);
		chk("units", 16'h0031, units);
		sdc_eeprom_model_i.load(8'he3, 8'h00);
		wr(1'h0, 16'h0141, 16'hffff);
		wr(1'h1, 16'h0150, 16'hffff);
		rd(1'h0, 16'h0141);
		chk("cfg", 16'h0011, rdv);
		rd(1'h0, 16'h0150);
		chk("io cfg", 16'h0000, rdv);
		wr(1'h0, 16'h0120, 16'h0004);
		wr(1'h1, 16'h0130, 16'h0002);
		rd(1'h1, 16'h0130);
		chk("status", 16'h0004, rdv);
		chk("event", 16'h0000, al_event_request0);
		sdc_eeprom_model_i.load(8'h00, 8'h00);
		wr(1'h1, 16'h0130, 16'h0032);
		rd(1'h1, 16'h0130);
		chk("status", 16'h0032, rdv);
		wr(1'h0, 16'h0120, 16'h0002);
		chk("event", 16'h0001, al_event_request0);
		rd(1'h1, 16'h0120);
		chk("event", 16'h0001, al_event_request0);
		wr(1'h1, 16'h0120, 16'h0000);
		chk("event", 16'h0000, al_event_request0);
		foreach (rows[i]) dio_row(rows[i]);
		ack_by_write_cfg <= 1'h0;
		local_if_config_invalid <= 1'h0;
		local_if_active <= 1'h1;
		do_reset();
		rd(1'h0, 16'h014e);
		chk("info", 16'h0004, rdv);
		wr(1'h0, 16'h0120, 16'h0001);
		rd(1'h1, 16'h0120);
		chk("event", 16'h0000, al_event_request0);
		tally_and_finish();
	end
endmodule // slave_config_and_dio_control_tb
`default_nettype wire
